// file: flag_dp_pkg.sv
// shared constants and carrier types for the test and xor flag datapath
package flag_dp_pkg;

  localparam int unsigned APB_AW = 8;

  // register byte addresses
  localparam logic [APB_AW-1:0] CTRL_ADDR = 8'h00;
  localparam logic [APB_AW-1:0] SRC_ADDR  = 8'h04;
  localparam logic [APB_AW-1:0] DST_ADDR  = 8'h08;
  localparam logic [APB_AW-1:0] SR_ADDR   = 8'h0C;

  // control register fields
  localparam int unsigned CTRL_OP_BIT   = 0;
  localparam int unsigned CTRL_BYTE_BIT = 1;
  localparam int unsigned CTRL_DREG_BIT = 2;
  localparam int unsigned CTRL_GO_BIT   = 3;
  localparam int unsigned CTRL_BUSY_BIT = 8;
  localparam int unsigned CTRL_DONE_BIT = 9;

  // status register fields
  localparam int unsigned SR_C_BIT      = 0;
  localparam int unsigned SR_Z_BIT      = 1;
  localparam int unsigned SR_N_BIT      = 2;
  localparam int unsigned SR_GIE_BIT    = 3;
  localparam int unsigned SR_CPU_OFF_BIT_BIT = 4;
  localparam int unsigned SR_OSCILLATOR_OFF_BIT_BIT = 5;
  localparam int unsigned SR_V_BIT      = 8;
  localparam logic [15:0] SR_MODE_MASK  = 16'h0038;

  // reset values
  localparam logic [15:0] SR_RST  = 16'h0000;
  localparam logic [15:0] SRC_RST = 16'h0000;
  localparam logic [15:0] DST_RST = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // operand widths
  localparam logic [15:0] ONES_WORD = 16'hFFFF;
  localparam logic [7:0]  ONES_BYTE = 8'hFF;
  localparam int unsigned WORD_MSB  = 15;
  localparam int unsigned BYTE_MSB  = 7;

  typedef enum logic {
    OP_TEST = 1'b0,
    OP_XOR  = 1'b1
  } op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WB   = 2'b11
  } seq_type;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic v;
    logic n;
    logic z;
    logic c;
  } flags_type;

endpackage

// file: test_xor_alu.sv
// combinational result and flag unit for test-against-zero and exclusive or
module test_xor_alu
  import flag_dp_pkg::*;
(
  input  wire op_type      op_i,
  input  wire logic        byte_i,
  input  wire logic        dst_reg_i,
  input  wire logic [15:0] src_i,
  input  wire logic [15:0] dst_i,
  output logic      [15:0] dst_o,
  output flags_type        flags_o
);

  logic [16:0] tst_w;
  logic [8:0]  test_against_zero_byte;
  logic [15:0] xor_w;
  logic [15:0] val;
  logic        cy;
  logic        sgn_s;
  logic        sgn_d;
  logic        sgn_r;
  logic        zr;

  always_comb begin
    tst_w = {1'b0, dst_i} + {1'b0, ONES_WORD} + 17'h00001;
    test_against_zero_byte = {1'b0, dst_i[7:0]} + {1'b0, ONES_BYTE} + 9'h001;
    xor_w = src_i ^ dst_i;
    if (op_i == OP_TEST) begin
      val = byte_i ? {8'h00, test_against_zero_byte[7:0]} : tst_w[15:0];
      cy  = byte_i ? test_against_zero_byte[8] : tst_w[16];
    end else begin
      val = byte_i ? {8'h00, xor_w[7:0]} : xor_w;
      cy  = 1'b0;
    end
    // sign taken from bit seven or bit fifteen by width
    sgn_s = byte_i ? src_i[BYTE_MSB] : src_i[WORD_MSB];
    sgn_d = byte_i ? dst_i[BYTE_MSB] : dst_i[WORD_MSB];
    sgn_r = byte_i ? val[BYTE_MSB] : val[WORD_MSB];
    zr    = byte_i ? (val[7:0] == 8'h00) : (val == 16'h0000);
    flags_o.n = sgn_r;
    flags_o.z = zr;
    if (op_i == OP_TEST) begin
      // adding all ones plus one always carries and never overflows
      flags_o.c = cy;
      flags_o.v = 1'b0;
    end else begin
      flags_o.c = ~zr;
      flags_o.v = sgn_s & sgn_d;
    end
    if (op_i == OP_TEST) begin
      dst_o = dst_i;
    end else if (!byte_i) begin
      dst_o = xor_w;
    end else if (dst_reg_i) begin
      dst_o = {8'h00, xor_w[7:0]};
    end else begin
      dst_o = {dst_i[15:8], xor_w[7:0]};
    end
  end

endmodule

// file: test_and_xor_flag_datapath.sv
// apb-controlled test-against-zero and exclusive-or datapath with status flags
//
// Overview of operation
// - test adds all-ones plus one to destination, updates flags, destination kept
// - byte test looks only at the low byte with an eight-bit all-ones
// - test sets negative flag for negative operand, clears it otherwise
// - test sets zero flag when operand is zero, clears it otherwise
// - test always sets carry and clears overflow
// - oscillator-off, cpu-off and interrupt enable bits never change
// - word width unless byte selected; byte selects byte operation
// - exclusive or of source and destination written to destination, source kept
// - exclusive or copies result sign bit into negative flag
// - exclusive or sets zero flag for zero result, clears otherwise
// - exclusive or carry is the inverse of zero
// - exclusive or overflow set only when both operands negative
// - byte exclusive or into a register clears the upper byte; byte test keeps it
//
// Our own choices: the register addresses and register access over APB.
module test_and_xor_flag_datapath
  import flag_dp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire apb_req_type apb_i,
  output apb_rsp_type      apb_o,
  output logic      [15:0] sr_o,
  output logic      [15:0] dst_o,
  output logic             busy_o
);

  typedef struct packed {
    seq_type     seq;
    op_type      op;
    logic        byte_mode;
    logic        dst_reg;
    logic        done;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] sr;
    logic [15:0] res;
    flags_type   flg;
    apb_rsp_type rsp;
  } state_type;

  localparam state_type STATE_RST = '{
    seq:       ST_IDLE,
    op:        OP_TEST,
    byte_mode: 1'b0,
    dst_reg:   1'b0,
    done:      1'b0,
    src:       SRC_RST,
    dst:       DST_RST,
    sr:        SR_RST,
    res:       DST_RST,
    flg:       4'h0,
    rsp:       '{prdata: RD_ZERO, pready: 1'b0, pslverr: 1'b0}
  };

  state_type   cur_r;
  state_type   cur_nxt;
  logic [15:0] alu_dst;
  flags_type   alu_flags;
  logic        acc;
  logic        fin;
  logic        busy;
  logic [31:0] rdata;
  logic        hit;

  // operand unit works on the held operands during the execute state
  test_xor_alu u_alu (
    .op_i      (cur_r.op),
    .byte_i    (cur_r.byte_mode),
    .dst_reg_i (cur_r.dst_reg),
    .src_i     (cur_r.src),
    .dst_i     (cur_r.dst),
    .dst_o     (alu_dst),
    .flags_o   (alu_flags)
  );

  always_comb begin
    cur_nxt = cur_r;
    busy    = (cur_r.seq != ST_IDLE);
    // first access cycle answers next edge, write lands when pready is seen
    acc     = apb_i.psel && apb_i.penable && !cur_r.rsp.pready;
    fin     = apb_i.psel && apb_i.penable && cur_r.rsp.pready;
    rdata   = RD_ZERO;
    hit     = 1'b1;
    case (apb_i.paddr)
      CTRL_ADDR: begin
        rdata = {22'h000000, cur_r.done, busy, 5'h00,
                 cur_r.dst_reg, cur_r.byte_mode, cur_r.op};
      end
      SRC_ADDR: begin
        rdata = {16'h0000, cur_r.src};
      end
      DST_ADDR: begin
        rdata = {16'h0000, cur_r.dst};
      end
      SR_ADDR: begin
        rdata = {16'h0000, cur_r.sr};
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    cur_nxt.rsp.pready  = acc;
    cur_nxt.rsp.pslverr = acc && !hit;
    cur_nxt.rsp.prdata  = (acc && !apb_i.pwrite) ? rdata : RD_ZERO;

    // register writes; operand and setup writes are ignored while busy
    if (fin && apb_i.pwrite && hit) begin
      case (apb_i.paddr)
        CTRL_ADDR: begin
          if (apb_i.pwdata[CTRL_DONE_BIT]) begin
            cur_nxt.done = 1'b0;
          end
          if (!busy) begin
            cur_nxt.op        = op_type'(apb_i.pwdata[CTRL_OP_BIT]);
            cur_nxt.byte_mode = apb_i.pwdata[CTRL_BYTE_BIT];
            cur_nxt.dst_reg   = apb_i.pwdata[CTRL_DREG_BIT];
            if (apb_i.pwdata[CTRL_GO_BIT]) begin
              cur_nxt.seq = ST_EXEC;
            end
          end
        end
        SRC_ADDR: begin
          if (!busy) begin
            cur_nxt.src = apb_i.pwdata[15:0];
          end
        end
        DST_ADDR: begin
          if (!busy) begin
            cur_nxt.dst = apb_i.pwdata[15:0];
          end
        end
        SR_ADDR: begin
          if (!busy) begin
            cur_nxt.sr = apb_i.pwdata[15:0];
          end
        end
        default: begin
          cur_nxt.sr = cur_r.sr;
        end
      endcase
    end

    // execution sequence; completion set wins over a done clear
    case (cur_r.seq)
      ST_IDLE: begin
        cur_nxt.res = cur_r.res;
      end
      ST_EXEC: begin
        cur_nxt.res = alu_dst;
        cur_nxt.flg = alu_flags;
        cur_nxt.seq = ST_WB;
      end
      ST_WB: begin
        cur_nxt.dst = cur_r.res;
        // only the four flag bits are written, mode bits untouched
        cur_nxt.sr[SR_C_BIT] = cur_r.flg.c;
        cur_nxt.sr[SR_Z_BIT] = cur_r.flg.z;
        cur_nxt.sr[SR_N_BIT] = cur_r.flg.n;
        cur_nxt.sr[SR_V_BIT] = cur_r.flg.v;
        cur_nxt.done = 1'b1;
        cur_nxt.seq  = ST_IDLE;
      end
      default: begin
        cur_nxt.seq = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_r <= STATE_RST;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign apb_o  = cur_r.rsp;
  assign sr_o   = cur_r.sr;
  assign dst_o  = cur_r.dst;
  // low bit of the sequence code is one in both busy states
  assign busy_o = cur_r.seq[0];

  // checking helpers
  logic        chk_wb;
  logic        chk_tst;
  logic        chk_dmsb;
  logic        chk_smsb;
  logic        chk_dzero;
  logic        chk_bneg;
  logic [15:0] chk_xor;
  logic [15:0] chk_keep;
  logic [15:0] chk_breg;
  logic        chk_map;
  logic        chk_srwr;
  logic        chk_dclr;

  assign chk_wb    = (cur_r.seq == ST_WB);
  assign chk_tst   = (cur_r.op == OP_TEST);
  assign chk_dmsb  = cur_r.byte_mode ? cur_r.dst[BYTE_MSB] : cur_r.dst[WORD_MSB];
  assign chk_smsb  = cur_r.byte_mode ? cur_r.src[BYTE_MSB] : cur_r.src[WORD_MSB];
  assign chk_dzero = cur_r.byte_mode ? (cur_r.dst[7:0] == 8'h00)
                                     : (cur_r.dst == 16'h0000);
  assign chk_bneg  = chk_smsb & chk_dmsb;
  assign chk_xor   = cur_r.src ^ cur_r.dst;
  assign chk_keep  = {cur_r.dst[15:8], chk_xor[7:0]};
  assign chk_breg  = {8'h00, chk_xor[7:0]};
  assign chk_map   = (apb_i.paddr == CTRL_ADDR) || (apb_i.paddr == SRC_ADDR) ||
                     (apb_i.paddr == DST_ADDR) || (apb_i.paddr == SR_ADDR);
  assign chk_srwr  = fin && apb_i.pwrite && (apb_i.paddr == SR_ADDR);
  assign chk_dclr  = fin && apb_i.pwrite && (apb_i.paddr == CTRL_ADDR) &&
                     apb_i.pwdata[CTRL_DONE_BIT];

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  a_tst_dst_kept:
    assert property (chk_wb && chk_tst |=> $stable(cur_r.dst) && cur_r.done)
    else $error("test changed its destination");

  a_tst_byte_view:
    assert property (chk_wb && chk_tst && cur_r.byte_mode |=>
                     cur_r.sr[SR_Z_BIT] == (cur_r.dst[7:0] == 8'h00) &&
                     cur_r.sr[SR_N_BIT] == cur_r.dst[7])
    else $error("byte test flags not from low byte");

  a_tst_neg_flag:
    assert property (chk_wb && chk_tst |=> cur_r.sr[SR_N_BIT] == chk_dmsb)
    else $error("test negative flag wrong");

  a_tst_zero_flag:
    assert property (chk_wb && chk_tst |=> cur_r.sr[SR_Z_BIT] == chk_dzero)
    else $error("test zero flag wrong");

  a_tst_carry_ovf:
    assert property (chk_wb && chk_tst |=> cur_r.sr[SR_C_BIT] && !cur_r.sr[SR_V_BIT])
    else $error("test carry or overflow wrong");

  a_mode_bits_kept:
    assert property (chk_wb |=> (cur_r.sr & SR_MODE_MASK) ==
                                ($past(cur_r.sr) & SR_MODE_MASK))
    else $error("mode bits changed by operation");

  a_xor_byte_mem:
    assert property (chk_wb && !chk_tst && cur_r.byte_mode && !cur_r.dst_reg |=>
                     cur_r.dst == $past(chk_keep))
    else $error("byte xor to memory touched upper byte");

  a_xor_word_res:
    assert property (chk_wb && !chk_tst && !cur_r.byte_mode |=>
                     cur_r.dst == $past(chk_xor) && $stable(cur_r.src))
    else $error("word xor result wrong");

  a_xor_neg_flag:
    assert property (chk_wb && !chk_tst |=> cur_r.sr[SR_N_BIT] == chk_dmsb)
    else $error("xor negative flag wrong");

  a_xor_zero_flag:
    assert property (chk_wb && !chk_tst |=> cur_r.sr[SR_Z_BIT] == chk_dzero)
    else $error("xor zero flag wrong");

  a_xor_carry_flag:
    assert property (chk_wb && !chk_tst |=> cur_r.sr[SR_C_BIT] == !chk_dzero)
    else $error("xor carry flag wrong");

  a_xor_ovf_flag:
    assert property (chk_wb && !chk_tst |=> cur_r.sr[SR_V_BIT] == $past(chk_bneg))
    else $error("xor overflow flag wrong");

  a_byte_reg_upper:
    assert property (chk_wb && !chk_tst && cur_r.byte_mode && cur_r.dst_reg |=>
                     cur_r.dst == $past(chk_breg))
    else $error("byte xor to register kept upper byte");

  a_word_sign_bit:
    assert property (chk_wb && !cur_r.byte_mode |=> cur_r.sr[SR_N_BIT] == cur_r.dst[15])
    else $error("word sign not taken from bit fifteen");

  a_go_to_done:
    assert property ($rose(busy_o) |-> ##2 !busy_o && cur_r.done)
    else $error("operation did not complete in two cycles");

  // bus response checks
  a_rdy_after_access:
    assert property (apb_i.psel && apb_i.penable && !apb_o.pready |=> apb_o.pready)
    else $error("no ready after the first access cycle");

  a_rdy_one_pulse:
    assert property (apb_o.pready |=> !apb_o.pready)
    else $error("ready stood longer than one cycle");

  a_err_with_rdy:
    assert property (apb_o.pslverr |-> apb_o.pready)
    else $error("error response without ready");

  a_err_unmapped:
    assert property (apb_i.psel && apb_i.penable && !apb_o.pready |=>
                     apb_o.pslverr == !$past(chk_map))
    else $error("error response does not match the address map");

  a_rdata_idle_zero:
    assert property (!apb_o.pready |-> apb_o.prdata == RD_ZERO)
    else $error("read data shown outside a ready cycle");

  // operation checks
  a_busy_matches_seq:
    assert property (busy_o == (cur_r.seq != ST_IDLE))
    else $error("busy output disagrees with the sequence");

  a_exec_to_wb:
    assert property (cur_r.seq == ST_EXEC |=> chk_wb)
    else $error("execute not followed by writeback");

  a_op_done_idle:
    assert property (chk_wb |=> cur_r.done && !busy_o)
    else $error("operation did not finish after writeback");

  a_done_sticky:
    assert property (cur_r.done && !chk_dclr |=> cur_r.done)
    else $error("done dropped without a clear");

  a_done_clear:
    assert property (chk_dclr && !chk_wb |=> !cur_r.done)
    else $error("done not cleared by a write of one");

  a_src_kept_busy:
    assert property (busy_o |=> $stable(cur_r.src))
    else $error("source changed during an operation");

  a_tst_res_equal:
    assert property (chk_wb && chk_tst |-> cur_r.res == cur_r.dst)
    else $error("test result differs from its destination");

  a_xor_byte_low:
    assert property (chk_wb && !chk_tst && cur_r.byte_mode |=>
                     cur_r.dst[7:0] == $past(chk_xor[7:0]))
    else $error("byte xor low byte wrong");

  a_byte_sign_bit:
    assert property (chk_wb && cur_r.byte_mode |=> cur_r.sr[SR_N_BIT] == cur_r.dst[BYTE_MSB])
    else $error("byte sign not taken from bit seven");

  a_sr_mode_sw_only:
    assert property (!chk_srwr |=> (cur_r.sr & SR_MODE_MASK) ==
                                   ($past(cur_r.sr) & SR_MODE_MASK))
    else $error("mode bits changed without a status write");

endmodule

// file: apb_cpu_model.sv
// apb master model standing in for the cpu side of the datapath
module apb_cpu_model
  import flag_dp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire apb_rsp_type apb_i,
  output apb_req_type      apb_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial apb_o = '0;

  // one transfer, entered just after a rising edge; one idle cycle after it
  task automatic xfer(input logic wr, input logic [APB_AW-1:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    apb_o <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: wd};
    @(posedge clk_sys_i);
    apb_o.penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (apb_i.pready !== 1'b1);
    rd = apb_i.prdata;
    er = apb_i.pslverr;
    // released lines show the inverse, not the stale request
    apb_o <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~ad, pwdata: ~wd};
    @(posedge clk_sys_i);
  endtask
endmodule

// file: test_and_xor_flag_datapath_tb.sv
// self-checking bench for the test and xor flag datapath
module test_and_xor_flag_datapath_tb
  import flag_dp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [2:0]  md;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] sri;
    logic [15:0] dsx;
    logic [15:0] srx;
  } row_type;

  logic        clk_sys_i;
  logic        rst_n_i;
  apb_req_type apb_req;
  apb_rsp_type apb_rsp;
  logic [15:0] sr_w;
  logic [15:0] dst_w;
  logic        busy_w;
  logic [31:0] rd;
  logic        er;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  // md is {dst_reg, byte, op}
  row_type     rows [12] = '{
    '{3'h0, 16'h0000, 16'h8000, 16'h0038, 16'h8000, 16'h003D},
    '{3'h0, 16'h0000, 16'h0000, 16'h0107, 16'h0000, 16'h0003},
    '{3'h6, 16'h0000, 16'hFF80, 16'h0000, 16'hFF80, 16'h0005},
    '{3'h2, 16'h0000, 16'h1200, 16'h0010, 16'h1200, 16'h0013},
    '{3'h0, 16'h0000, 16'h7FFF, 16'h0020, 16'h7FFF, 16'h0021},
    '{3'h1, 16'h8001, 16'h8001, 16'h0008, 16'h0000, 16'h010A},
    '{3'h1, 16'h00F0, 16'h0F0F, 16'h0000, 16'h0FFF, 16'h0001},
    '{3'h1, 16'h8000, 16'h0001, 16'h0030, 16'h8001, 16'h0035},
    '{3'h3, 16'h1280, 16'hAB81, 16'h0000, 16'hAB01, 16'h0101},
    '{3'h7, 16'h00FF, 16'h5A0F, 16'h0038, 16'h00F0, 16'h003D},
    '{3'h7, 16'h0055, 16'hFF55, 16'h0000, 16'h0000, 16'h0002},
    '{3'h5, 16'h7FFF, 16'h8000, 16'h0000, 16'hFFFF, 16'h0005}
  };

  test_and_xor_flag_datapath dut (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .apb_i     (apb_req),
    .apb_o     (apb_rsp),
    .sr_o      (sr_w),
    .dst_o     (dst_w),
    .busy_o    (busy_w)
  );

  apb_cpu_model mst (
    .clk_sys_i (clk_sys_i),
    .apb_i     (apb_rsp),
    .apb_o     (apb_req)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [APB_AW-1:0] a, input logic [15:0] d);
    mst.xfer(1'b1, a, {16'h0000, d}, rd, er);
    chk({31'h0, er}, 32'h0000_0000);
  endtask

  task automatic rdc(input logic [APB_AW-1:0] a, input logic [31:0] exp);
    mst.xfer(1'b0, a, 32'h0000_0000, rd, er);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0000_0000);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles >= 2000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk({16'h0000, sr_w}, 32'h0000_0000);
    chk({16'h0000, dst_w}, 32'h0000_0000);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc(CTRL_ADDR, RD_ZERO);
    rdc(SR_ADDR, RD_ZERO);
    foreach (rows[i]) begin
      wr(SRC_ADDR, rows[i].src);
      wr(DST_ADDR, rows[i].dst);
      wr(SR_ADDR, rows[i].sri);
      wr(CTRL_ADDR, {12'h000, 1'b1, rows[i].md});
      chk({31'h0, busy_w}, 32'h0000_0001);
      @(posedge clk_sys_i);
      rdc(DST_ADDR, {16'h0000, rows[i].dsx});
      rdc(SR_ADDR, {16'h0000, rows[i].srx});
      rdc(SRC_ADDR, {16'h0000, rows[i].src});
      rdc(CTRL_ADDR, {22'h000000, 1'b1, 6'h00, rows[i].md});
      chk({16'h0000, sr_w}, {16'h0000, rows[i].srx});
      chk({16'h0000, dst_w}, {16'h0000, rows[i].dsx});
      chk({31'h0, busy_w}, 32'h0000_0000);
    end
    // unmapped place answers with an error and zero data
    mst.xfer(1'b0, 8'h10, 32'h0000_0000, rd, er);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, RD_ZERO);
    // a written one clears the sticky done bit
    wr(CTRL_ADDR, 16'h0200);
    rdc(CTRL_ADDR, RD_ZERO);
    // word test again so that done is set before the reset
    wr(CTRL_ADDR, 16'h0008);
    @(posedge clk_sys_i);
    rdc(CTRL_ADDR, 32'h0000_0200);
    // second reset in mid-run clears the outputs at once
    rst_n_i <= 1'b0;
    @(posedge clk_sys_i);
    chk({16'h0000, sr_w}, 32'h0000_0000);
    chk({16'h0000, dst_w}, 32'h0000_0000);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc(DST_ADDR, RD_ZERO);
    rdc(CTRL_ADDR, RD_ZERO);
    rdc(SR_ADDR, RD_ZERO);
    finish_test();
  end
endmodule
